// ---- verilog/adc_conversion_control.sv ----
// Sequencer for a 10-bit successive-approximation converter with an APB
// register file, abort handling and result justification.
// Assumes the comparator and RC clock arrive asynchronously; sleep_i
// comes from logic on clock_i.
// Notes on behaviour
// - conversion lasts exactly eleven conversion periods
// - select code picks divider or internal RC
// - writing go starts; go reads one while busy
// - completion clears go, sets done flag, interrupts
// - clearing go aborts; results keep old value
// - after abort wait two periods, then acquire
// - bit 7 picks right or left justification
// - bit 6 picks external reference or supply
// - channel field connects input n to hold
// - bit 0 powers the converter
// - successive approximation stores ten-bit result
// - analog select disables pin digital buffer
// - internal RC delays start one instruction
// - sleep aborts non-RC conversion, powers off
// - reset aborts and turns off, results kept
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "adc_conv_consts.svh"

module adc_conversion_control #(
  parameter int ADDR_W = 12,
  parameter int RES_W = 10
) (
  input wire logic clock_i,                 // 50 MHz oscillator
  input wire logic rst_n_i,                 // Async reset, active low
  input wire logic psel_i,                  // APB select
  input wire logic penable_i,               // APB enable
  input wire logic pwrite_i,                // APB write
  input wire logic [ADDR_W-1:0] paddr_i,    // APB byte address
  input wire logic [31:0] pwdata_i,         // APB write data
  output logic [31:0] prdata_o,             // APB read data
  output logic pready_o,                    // APB ready
  output logic pslverr_o,                   // APB error, unmapped address
  input wire logic sleep_i,                 // Device in sleep
  input wire logic rc_clk_i,                // Internal RC oscillator
  input wire logic comp_i,                  // Comparator: input above DAC
  output adc_conv_pkg::core_t core_o,       // Analog core drive
  output logic [7:0] pin_dig_in_off_o,      // Pin digital buffer disable
  output logic irq_o                        // Conversion done interrupt
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  adc_conv_pkg::ctrl_t ctrl_q;
  adc_conv_pkg::conv_state_t state_q;
  adc_conv_pkg::conv_state_t state_d;
  adc_conv_pkg::core_t core_d;
  logic go_q;
  logic [2:0] clk_sel_q;
  logic [7:0] pin_analog_select_reg_q;
  logic done_flag_q;
  logic irq_en_q;
  logic [RES_W-1:0] result_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] mask_q;
  logic [3:0] tad_cnt_q;
  logic [2:0] dly_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic comp_m_q;
  logic comp_s_q;
  logic rc_m_q;
  logic rc_s_q;
  logic rc_p_q;
  // Reset image of the control register, sliced into its fields below
  localparam logic [7:0] RST_CTRL_V = `RST_CTRL;

  // ---------------------------------------------------------------------
  // Synchronisers and conversion clock
  // ---------------------------------------------------------------------
  // Two stages each; the RC clock adds a third flop so its rising edge can be detected
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comp_m_q <= 1'b0;
      comp_s_q <= 1'b0;
      rc_m_q <= 1'b0;
      rc_s_q <= 1'b0;
      rc_p_q <= 1'b0;
    end else begin
      comp_m_q <= comp_i;
      comp_s_q <= comp_m_q;
      rc_m_q <= rc_clk_i;
      rc_s_q <= rc_m_q;
      rc_p_q <= rc_s_q;
    end
  end

  logic rc_edge_w;
  logic rc_sel_w;
  logic tad_tick_w;
  logic div_clear_w;
  logic sw_abort_w;
  logic sleep_abort_w;
  assign rc_edge_w = rc_s_q & ~rc_p_q;
  assign rc_sel_w = (clk_sel_q[1:0] == 2'h3);
  // Divider phase restarts at each start and abort so every divided period is whole;
  // otherwise the abort wait could end up to one period short
  assign div_clear_w = (state_q == adc_conv_pkg::ST_IDLE) ||
                       (state_q == adc_conv_pkg::ST_START_DLY) ||
                       sw_abort_w || sleep_abort_w;

  tad_divider #(.CNT_W(6)) u_tad (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .clear_i(div_clear_w),
    .sel_i(clk_sel_q),
    .rc_edge_i(rc_edge_w),
    .tick_o(tad_tick_w)
  );

  // ---------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------
  logic setup_w;
  logic wr_w;
  logic [ADDR_W-1:0] a_ctrl_w, a_flag_w, a_hi_w, a_lo_w, a_ien_w, a_pin_analog_select_reg_w, a_clk_w;
  logic hit_w;
  logic wr_ctrl_w;
  logic wr_flag_w;
  assign a_ctrl_w = ADDR_W'({`IDX_CTRL, 2'b00});
  assign a_flag_w = ADDR_W'({`IDX_FLAG, 2'b00});
  assign a_hi_w = ADDR_W'({`IDX_RES_HI, 2'b00});
  assign a_lo_w = ADDR_W'({`IDX_RES_LO, 2'b00});
  assign a_ien_w = ADDR_W'({`IDX_IRQ_EN, 2'b00});
  assign a_pin_analog_select_reg_w = ADDR_W'({`IDX_PIN_ANALOG_SELECT_REG, 2'b00});
  assign a_clk_w = ADDR_W'({`IDX_CLKCFG, 2'b00});
  assign setup_w = psel_i & ~penable_i;
  assign wr_w = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
  assign hit_w = (paddr_i == a_ctrl_w) || (paddr_i == a_flag_w) ||
                 (paddr_i == a_hi_w) || (paddr_i == a_lo_w) ||
                 (paddr_i == a_ien_w) || (paddr_i == a_pin_analog_select_reg_w) ||
                 (paddr_i == a_clk_w);
  assign wr_ctrl_w = wr_w && (paddr_i == a_ctrl_w);
  assign wr_flag_w = wr_w && (paddr_i == a_flag_w);

  // Result placement by justification
  logic [7:0] res_hi_w;
  logic [7:0] res_lo_w;
  assign res_hi_w = ctrl_q.result_justify ? {6'h00, result_q[9:8]} : result_q[9:2];
  assign res_lo_w = ctrl_q.result_justify ? result_q[7:0] : {result_q[1:0], 6'h00};

  logic [7:0] ctrl_rd_w;
  logic [31:0] rd_w;
  assign ctrl_rd_w = {ctrl_q.result_justify, ctrl_q.reference_select, 1'b0,
                      ctrl_q.channel_select, go_q, ctrl_q.converter_on};
  assign rd_w = (paddr_i == a_ctrl_w) ? {24'h0, ctrl_rd_w} :
                (paddr_i == a_flag_w) ? {24'h0, 1'b0, done_flag_q, 6'h00} :
                (paddr_i == a_ien_w) ? {24'h0, 1'b0, irq_en_q, 6'h00} :
                (paddr_i == a_hi_w) ? {24'h0, res_hi_w} :
                (paddr_i == a_lo_w) ? {24'h0, res_lo_w} :
                (paddr_i == a_pin_analog_select_reg_w) ? {24'h0, pin_analog_select_reg_q} :
                (paddr_i == a_clk_w) ? {24'h0, 1'b0, clk_sel_q, 4'h0} : 32'h0;

  // Answer one cycle after setup: zero wait states, registered data
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup_w;
      pslverr_q <= setup_w & ~hit_w;
      if (setup_w) begin
        prdata_q <= rd_w;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  logic go_wr1_w;
  logic start_w;
  logic busy_w;
  logic done_w;
  logic [RES_W-1:0] kept_w;
  assign go_wr1_w = wr_ctrl_w & pwdata_i[`B_GO];
  // Needs the converter already on; a go in the enabling write is dropped
  assign start_w = go_wr1_w & ctrl_q.converter_on & ~go_q &
                   (state_q == adc_conv_pkg::ST_IDLE);
  assign busy_w = (state_q == adc_conv_pkg::ST_CONVERT) ||
                  (state_q == adc_conv_pkg::ST_START_DLY);
  assign sw_abort_w = busy_w & wr_ctrl_w & ~pwdata_i[`B_GO];
  assign sleep_abort_w = busy_w & sleep_i & ~rc_sel_w;
  assign done_w = (state_q == adc_conv_pkg::ST_CONVERT) & tad_tick_w &
                  (tad_cnt_q == `CONV_LAST) & ~sw_abort_w & ~sleep_abort_w;
  // Keep the trial bit when the input sits above the DAC level
  assign kept_w = comp_s_q ? sar_q : (sar_q & ~mask_q);

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      adc_conv_pkg::ST_IDLE: begin
        if (start_w) begin
          state_d = rc_sel_w ? adc_conv_pkg::ST_START_DLY : adc_conv_pkg::ST_CONVERT;
        end
      end
      adc_conv_pkg::ST_START_DLY: begin
        if (sw_abort_w || sleep_abort_w) begin
          state_d = adc_conv_pkg::ST_ABORT_WAIT;
        end else if (dly_q == `INSTR_CYCLES - 3'h1) begin
          state_d = adc_conv_pkg::ST_CONVERT;
        end
      end
      adc_conv_pkg::ST_CONVERT: begin
        if (sw_abort_w || sleep_abort_w) begin
          state_d = adc_conv_pkg::ST_ABORT_WAIT;
        end else if (done_w) begin
          state_d = adc_conv_pkg::ST_IDLE;
        end
      end
      adc_conv_pkg::ST_ABORT_WAIT: begin
        if (tad_tick_w && tad_cnt_q == `ABORT_LAST) begin
          state_d = adc_conv_pkg::ST_IDLE;
        end
      end
      default: state_d = adc_conv_pkg::ST_IDLE;
    endcase
  end

  // State, period count, approximation register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= adc_conv_pkg::ST_IDLE;
      tad_cnt_q <= 4'h0;
      dly_q <= 3'h0;
      sar_q <= `RES_MSB_SET;
      mask_q <= `RES_MSB_SET;
    end else begin
      state_q <= state_d;
      dly_q <= (state_q == adc_conv_pkg::ST_START_DLY) ? dly_q + 3'h1 : 3'h0;
      if (state_d != state_q) begin
        tad_cnt_q <= 4'h0;
        sar_q <= `RES_MSB_SET;
        mask_q <= `RES_MSB_SET;
      end else if (tad_tick_w) begin
        tad_cnt_q <= tad_cnt_q + 4'h1;
        // First period is the hold; the next ten resolve one bit each
        if (state_q == adc_conv_pkg::ST_CONVERT && tad_cnt_q != 4'h0) begin
          sar_q <= kept_w | (mask_q >> 1);
          mask_q <= mask_q >> 1;
        end
      end
    end
  end

  // Results: no reset on purpose, a device reset must leave them intact
  always_ff @(posedge clock_i) begin
    if (done_w) begin
      result_q <= kept_w;
    end
  end

  // ---------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= adc_conv_pkg::ctrl_t'({RST_CTRL_V[7:6], RST_CTRL_V[4:2], RST_CTRL_V[0]});
      go_q <= 1'b0;
      clk_sel_q <= `RST_CLKCFG;
      pin_analog_select_reg_q <= `RST_PIN_ANALOG_SELECT_REG;
      irq_en_q <= 1'b0;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_q.result_justify <= pwdata_i[`B_JUSTIFY];
        ctrl_q.reference_select <= pwdata_i[`B_REF];
        ctrl_q.channel_select <= pwdata_i[`B_CHAN_HI:`B_CHAN_LO];
        ctrl_q.converter_on <= pwdata_i[`B_ON];
      end
      if (start_w) begin
        go_q <= 1'b1;
      end else if (done_w || sw_abort_w || sleep_abort_w) begin
        go_q <= 1'b0;
      end
      if (wr_w && paddr_i == a_clk_w) begin
        clk_sel_q <= pwdata_i[`B_CLK_HI:`B_CLK_LO];
      end
      if (wr_w && paddr_i == a_pin_analog_select_reg_w) begin
        pin_analog_select_reg_q <= pwdata_i[7:0];
      end
      if (wr_w && paddr_i == a_ien_w) begin
        irq_en_q <= pwdata_i[`B_DONE];
      end
    end
  end

  // Done flag: completion wins over a clearing write in the same cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_flag_q <= 1'b0;
    end else if (done_w) begin
      done_flag_q <= 1'b1;
    end else if (wr_flag_w) begin
      done_flag_q <= pwdata_i[`B_DONE];
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  always_comb begin
    core_d.powered = ctrl_q.converter_on & ~(sleep_i & ~rc_sel_w);
    core_d.ref_ext = ctrl_q.reference_select;
    core_d.channel = ctrl_q.channel_select;
    core_d.hold = (state_q == adc_conv_pkg::ST_CONVERT);
    core_d.dac_code = sar_q;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_o <= '0;
      pin_dig_in_off_o <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      core_o <= core_d;
      pin_dig_in_off_o <= pin_analog_select_reg_q;
      irq_q <= done_flag_q & irq_en_q;
    end
  end
  assign irq_o = irq_q;
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_done_count;
    @(posedge clock_i) disable iff (!rst_n_i)
      done_w |-> tad_tick_w && tad_cnt_q == 4'ha;
  endproperty
  a_done_count: assert property (p_done_count) else $error("done not at tad 11");

  property p_go_busy;
    @(posedge clock_i) disable iff (!rst_n_i)
      busy_w |-> go_q;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("go low while busy");

  property p_done_effects;
    @(posedge clock_i) disable iff (!rst_n_i)
      done_w |=> !go_q && done_flag_q ##1 (irq_o == irq_en_q);
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("done effects wrong");

  property p_result_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      !done_w |=> $stable(result_q);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed");

  property p_abort_wait;
    @(posedge clock_i) disable iff (!rst_n_i)
      sw_abort_w |=> state_q == adc_conv_pkg::ST_ABORT_WAIT && tad_cnt_q == 4'h0;
  endproperty
  a_abort_wait: assert property (p_abort_wait) else $error("abort wait missed");

  property p_justify;
    @(posedge clock_i) disable iff (!rst_n_i)
      (setup_w && paddr_i == a_hi_w && ctrl_q.result_justify) |=>
        prdata_o[31:2] == 30'h0;
  endproperty
  a_justify: assert property (p_justify) else $error("right justify high");

  property p_ref_chan;
    @(posedge clock_i) disable iff (!rst_n_i)
      1'b1 |=> core_o.ref_ext == $past(ctrl_q.reference_select) &&
               core_o.channel == $past(ctrl_q.channel_select);
  endproperty
  a_ref_chan: assert property (p_ref_chan) else $error("mux drive lag");

  property p_power_off;
    @(posedge clock_i) disable iff (!rst_n_i)
      !ctrl_q.converter_on |=> !core_o.powered;
  endproperty
  a_power_off: assert property (p_power_off) else $error("powered while off");

  property p_rc_delay;
    @(posedge clock_i) disable iff (!rst_n_i)
      (start_w && rc_sel_w && !sleep_i) |=>
        (state_q == adc_conv_pkg::ST_START_DLY && !wr_ctrl_w)[*4] ##1
        (state_q == adc_conv_pkg::ST_CONVERT || state_q == adc_conv_pkg::ST_ABORT_WAIT);
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start delay");

  property p_sleep_abort;
    @(posedge clock_i) disable iff (!rst_n_i)
      sleep_abort_w |=> !go_q && !busy_w ##1 !core_o.powered;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort");

  property p_flag_sticky;
    @(posedge clock_i) disable iff (!rst_n_i)
      (done_flag_q && !wr_flag_w) |=> done_flag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  c_done: cover property (@(posedge clock_i) disable iff (!rst_n_i) done_w);
  c_abort: cover property (@(posedge clock_i) disable iff (!rst_n_i) sw_abort_w);
  c_sleep: cover property (@(posedge clock_i) disable iff (!rst_n_i) sleep_abort_w);
  c_irq: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(irq_o));

endmodule

`default_nettype wire

// ---- verilog/adc_conv_consts.svh ----
// Constants for the conversion controller: register indices, bit positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the design files only.
`ifndef ADC_CONV_CONSTS_SVH
`define ADC_CONV_CONSTS_SVH

// Register indices; the APB byte address is four times the index
`define IDX_FLAG 8'h0c
`define IDX_RES_HI 8'h1e
`define IDX_CTRL 8'h1f
`define IDX_RES_LO 8'h20
`define IDX_IRQ_EN 8'h8c
`define IDX_PIN_ANALOG_SELECT_REG 8'h91
`define IDX_CLKCFG 8'h9f

// Control register bit positions
`define B_JUSTIFY 7
`define B_REF 6
`define B_CHAN_HI 4
`define B_CHAN_LO 2
`define B_GO 1
`define B_ON 0
// Done flag and its enable share one position
`define B_DONE 6
// Clock select field in the clock config register
`define B_CLK_HI 6
`define B_CLK_LO 4

// Reset values
`define RST_CTRL 8'h00
`define RST_CLKCFG 3'h0
`define RST_PIN_ANALOG_SELECT_REG 8'hff

// Timing
`define CONV_TADS 11
`define CONV_LAST 4'ha
`define ABORT_LAST 4'h1
`define CLK_NS 20
`define MIN_TAD_NS 1600
`define MIN_TAD_CYCLES ((`MIN_TAD_NS + `CLK_NS - 1) / `CLK_NS)
`define INSTR_CYCLES 3'h4
`define RES_MSB_SET 10'h200

`endif

// ---- verilog/adc_conv_pkg.sv ----
// Types for the conversion controller.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_conv_pkg;

  // Converter sequencing states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START_DLY = 4'h2,
    ST_CONVERT = 4'h4,
    ST_ABORT_WAIT = 4'h8
  } conv_state_t;

  // Control register fields
  typedef struct packed {
    logic result_justify;
    logic reference_select;
    logic [2:0] channel_select;
    logic converter_on;
  } ctrl_t;

  // Drive bundle towards the analog mux, sample-and-hold and DAC
  typedef struct packed {
    logic powered;
    logic ref_ext;
    logic [2:0] channel;
    logic hold;
    logic [9:0] dac_code;
  } core_t;

endpackage

// ---- verilog/tad_divider.sv ----
// Conversion clock tick generator: divides the oscillator or passes the
// internal RC edge through.
// Assumes rc_edge_i is already synchronised into clock_i.
`timescale 1ns/1ns
`default_nettype none

module tad_divider #(
  parameter int CNT_W = 6
) (
  input wire logic clock_i,           // Oscillator clock
  input wire logic rst_n_i,           // Async reset, active low
  input wire logic clear_i,           // Restart the period
  input wire logic [2:0] sel_i,       // Conversion clock select code
  input wire logic rc_edge_i,         // One-cycle internal RC edge
  output logic tick_o                 // One pulse per conversion period
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [2:0] exp_w;
  logic [CNT_W-1:0] last_w;
  logic rc_sel_w;
  logic div_tick_w;

  // Code to divide ratio: 000,100,001,101,010,110 give 2..64
  assign rc_sel_w = (sel_i[1:0] == 2'h3);
  assign exp_w = {sel_i[1:0], 1'b0} + {2'h0, sel_i[2]};
  assign last_w = CNT_W'((7'h02 << exp_w) - 7'h01);
  assign div_tick_w = (cnt_q == last_w);
  assign tick_o = clear_i ? 1'b0 : (rc_sel_w ? rc_edge_i : div_tick_w);
  assign cnt_d = (clear_i || div_tick_w || rc_sel_w) ? '0 : cnt_q + 1'b1;

  // Period counter
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Fastest setting: a tick every second cycle
  property p_div_two;
    @(posedge clock_i) disable iff (!rst_n_i)
      (tick_o && sel_i == 3'h0 && $stable(sel_i)) |=>
        (!tick_o || clear_i) ##1 (tick_o || clear_i || $past(clear_i) || $changed(sel_i));
  endproperty
  a_div_two: assert property (p_div_two) else $error("div2 period wrong");

endmodule

`default_nettype wire

// ---- bench/analog_core_model.sv ----
// Far-side model: analog mux and comparator; the hold drive is not modelled.
// Assumes the controller drives the trial code and channel on core_i.
`timescale 1ns/1ns
`default_nettype none

module analog_core_model (
  input wire logic clock_i,                // Oscillator clock
  input wire adc_conv_pkg::core_t core_i,  // Drive from the controller
  input wire logic [9:0] level_i [8],      // Level on each analog input
  output logic comp_o                      // 1 = input at or above trial
);
  // ----------------------------------------
  // Comparator
  // ----------------------------------------
  logic idle_q = 1'b0;
  // Unpowered core has no valid output, so show a changing level
  always @(posedge clock_i) idle_q <= ~idle_q;
  // Selected input against the trial code
  assign comp_o = core_i.powered ? (level_i[core_i.channel] >= core_i.dac_code) : idle_q;
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the conversion controller over APB.
// Assumes the design package, its header and the analog core model.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clock_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic sleep = 1'b0, rc = 1'b0, comp, prdy, perr, irq, e;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [7:0] pins, hi_q = 8'h00, lo_q = 8'h00;
  logic [9:0] lvl [8];
  adc_conv_pkg::core_t core;
  int errors = 0, tests_run = 0, n;
  logic [2:0] codes [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int divs [8] = '{2, 4, 8, 16, 32, 64, 0, 0};

  always #10 clock_i = ~clock_i;
  // RC oscillator, unrelated in phase to the oscillator
  always #1003 rc = ~rc;

  adc_conversion_control adc_conversion_control_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .sleep_i(sleep), .rc_clk_i(rc),
    .comp_i(comp), .core_o(core), .pin_dig_in_off_o(pins), .irq_o(irq));
  analog_core_model analog_core_model_inst (.clock_i(clock_i), .core_i(core),
    .level_i(lvl), .comp_o(comp));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    if (k == 20) errors++;
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Full conversion on a random channel, format and reference
  task automatic conv(input logic [2:0] code, input int div);
    logic [9:0] r;
    logic j, rf;
    logic [2:0] ch;
    int lo, hi;
    ch = $urandom % 8;
    j = $urandom % 2;
    rf = $urandom % 2;
    // Every divided clock is below the minimum period at this oscillator
    // rate, so only a rail level converts reliably with them
    r = div ? {10{lvl[ch][9]}} : lvl[ch];
    lvl[ch] <= r;
    lo = div ? 11 * div + 1 : 1000;
    hi = div ? 11 * div + 3 : 1140;
    wr(12'h27c, {code, 4'h0});
    rdc(12'h27c, {code, 4'h0});
    wr(12'h07c, {j, rf, 1'b0, ch, 2'b01});
    repeat (2) @(posedge clock_i);
    chk({core.powered, core.ref_ext, core.channel}, {1'b1, rf, ch});
    wr(12'h07c, {j, rf, 1'b0, ch, 2'b11});
    // Fast oscillator: the RC clock is only used while asleep
    sleep <= (div == 0);
    rdc(12'h07c, {j, rf, 1'b0, ch, 2'b11});
    chk(core.hold, div != 0);
    n = 3;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clock_i);
      n++;
    end
    sleep <= 1'b0;
    chk(n >= lo && n <= hi, 1);
    rdc(12'h07c, {j, rf, 1'b0, ch, 2'b01});
    hi_q = j ? {6'h0, r[9:8]} : r[9:2];
    lo_q = j ? r[7:0] : {r[1:0], 6'h0};
    rdc(12'h078, hi_q);
    rdc(12'h080, lo_q);
    // Later checks run with left justification selected
    hi_q = r[9:2];
    lo_q = {r[1:0], 6'h0};
    rdc(12'h030, 32'h40);
    wr(12'h030, 32'h0);
    repeat (2) @(posedge clock_i);
    chk(irq, 1'b0);
    rdc(12'h030, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h83fe));
    for (int i = 0; i < 8; i++) lvl[i] = $urandom % 1024;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rdc(12'h07c, 32'h0);
    rdc(12'h244, 32'hff);
    rdc(12'h004, 32'h0);
    chk(e, 1'b1);
    // Digital buffers follow the analog-select bits
    n = $urandom % 256;
    wr(12'h244, n[7:0]);
    repeat (2) @(posedge clock_i);
    chk(pins, n[7:0]);
    // Flag raised by software reaches the pin only when enabled
    wr(12'h030, 32'h40);
    repeat (2) @(posedge clock_i);
    chk(irq, 1'b0);
    wr(12'h230, 32'h40);
    repeat (2) @(posedge clock_i);
    chk(irq, 1'b1);
    wr(12'h030, 32'h0);
    for (int i = 0; i < 8; i++) conv(codes[i], divs[i]);
    // Go in the same write as power-up is ignored
    wr(12'h07c, 32'h0);
    wr(12'h07c, 32'h3);
    rdc(12'h07c, 32'h1);
    // Abort mid-conversion, then restart after the wait
    wr(12'h27c, 32'h60);
    wr(12'h07c, 32'h3);
    repeat (100) @(posedge clock_i);
    wr(12'h07c, 32'h1);
    rdc(12'h07c, 32'h1);
    repeat (200) @(posedge clock_i);
    rdc(12'h078, hi_q);
    rdc(12'h080, lo_q);
    rdc(12'h030, 32'h0);
    conv(3'h6, 64);
    // Sleep with the divided clock aborts and powers down
    wr(12'h27c, 32'h50);
    wr(12'h07c, 32'h3);
    repeat (20) @(posedge clock_i);
    sleep <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(core.powered, 1'b0);
    rdc(12'h07c, 32'h1);
    sleep <= 1'b0;
    repeat (200) @(posedge clock_i);
    rdc(12'h078, hi_q);
    rdc(12'h030, 32'h0);
    // Reset mid-conversion keeps the results
    wr(12'h07c, 32'h3);
    repeat (30) @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    chk(core.powered, 1'b0);
    rdc(12'h07c, 32'h0);
    rdc(12'h078, hi_q);
    rdc(12'h080, lo_q);
    end_sim();
  end

  // Watchdog, well past the expected run length
  initial begin
    #400000;
    errors++;
    end_sim();
  end
endmodule

`default_nettype wire
